// ===== src/lpm_ctrl.sv
`timescale 1ns/100ps
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int STBY_EXIT = STBY_EXIT_CYC
)(
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          cpu_halt_ready_in,
    input  wire lpm_wake_src_t wake_src_in,
    input  wire logic          periph_irq_in,
    input  wire logic          vref_on_in,
    input  wire logic [2:0]    wake_pin_in,
    input  wire logic          external_reset_pin_n_in,
    input  wire logic          independent_watchdog_rst_in,
    input  wire logic          independent_watchdog_run_in,
    input  wire logic          fast_osc_req_in,
    output lpm_pwr_t           pwr_out,
    output logic [15:0]        cpu_freq_khz_out,
    output logic               cpu_wake_out,
    output logic               core_reset_out
);

    typedef enum logic [2:0] {ST_RUN, ST_LPRUN, ST_SLEEP, ST_LPSLEEP, ST_STOP, ST_STBY, ST_WAKE} lpm_state_t;

    function automatic logic [15:0] cap_of(input logic [1:0] rng);
        cap_of = (rng == 2'h1) ? FMAX_R1 : (rng == 2'h2) ? FMAX_R2 : FMAX_R3;
    endfunction

    function automatic logic ws_of(input logic [1:0] rng, input logic [15:0] f);
        ws_of = (rng == 2'h1) ? (f > FWS_R1) : (rng == 2'h2) ? (f > FWS_R2) : 1'b0;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NS = $bits(lpm_wake_src_t) + 9;
    logic [NS-1:0] raw, meta_q, sync_q;
    assign raw = {wake_src_in, periph_irq_in, vref_on_in, wake_pin_in, external_reset_pin_n_in,
                  independent_watchdog_rst_in, independent_watchdog_run_in, fast_osc_req_in};

    always_ff @(posedge clk_in)
    begin
        meta_q <= raw;
        sync_q <= meta_q;
    end

    lpm_wake_src_t ws;
    logic          irq_s, vref_s, rstn_pin_s, wdg_rst_s, wdg_run_s, fast_req_s;
    logic [2:0]    pin_s, pin_prev_q;
    assign {ws, irq_s, vref_s, pin_s, rstn_pin_s, wdg_rst_s, wdg_run_s, fast_req_s} = sync_q;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    lpm_state_t  state_q, state_d;
    logic [11:0] ctrl_q;
    logic [15:0] freq_q;
    logic [8:0]  wake_q;
    logic        step_err_q, lprun_err_q, stby_exit_q, cpu_wake_q;
    logic [15:0] guard_q, cnt_q;
    lpm_pwr_t    pwr_d, pwr_q;

    wire [2:0]  mode_req = ctrl_q[CTRL_MODE_LSB +: 3];
    wire        rtc_keep = ctrl_q[CTRL_RTC_KEEP];
    wire [1:0]  range = ctrl_q[CTRL_RANGE_LSB +: 2];
    wire [15:0] f_cap = cap_of(range);
    wire        capped = freq_q > f_cap;
    wire [15:0] f_eff = capped ? f_cap : freq_q;

    // ------------------------------------------------------------
    // Wake source decode
    // ------------------------------------------------------------
    wire       comp_w = ws.comp1 | (ws.comp2 & vref_s);
    wire       ser_w = |ws.serial | ws.low_power_timer;
    wire       rtc_w = |ws.rtc;
    wire       deep = state_q inside {ST_STOP, ST_STBY, ST_WAKE};
    wire [2:0] pin_rise = pin_s & ~pin_prev_q;
    wire       ext_interrupt_line_w = |ws.gpio | ws.voltage_detector | comp_w | ser_w;
    wire       stop_w = ext_interrupt_line_w | (rtc_keep & rtc_w);
    wire       sleep_w = irq_s | ext_interrupt_line_w | rtc_w;
    wire       stby_w = ~rstn_pin_s | |pin_rise | (rtc_keep & (wdg_rst_s | rtc_w));
    wire [8:0] src = {wdg_rst_s, ~rstn_pin_s, |pin_rise, ser_w, rtc_w & (rtc_keep | !deep), comp_w,
                      ws.voltage_detector, |ws.gpio, irq_s};
    wire       halting = (mode_req == MODE_SLEEP) | (mode_req == MODE_LPSLEEP) |
                         (mode_req == MODE_STOP) | (mode_req == MODE_STBY);
    wire       lprun_ok = freq_q <= FMAX_LPRUN;

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN, ST_LPRUN:
            begin
                if (halting && cpu_halt_ready_in)
                begin
                    case (mode_req)
                        MODE_SLEEP:   state_d = ST_SLEEP;
                        MODE_LPSLEEP: state_d = ST_LPSLEEP;
                        MODE_STOP:    state_d = ST_STOP;
                        default:      state_d = ST_STBY;
                    endcase
                end
                else if (mode_req == MODE_LPRUN && lprun_ok)
                    state_d = ST_LPRUN;
                else if (mode_req == MODE_RUN)
                    state_d = ST_RUN;
            end
            ST_SLEEP, ST_LPSLEEP:
                if (sleep_w)
                    state_d = ST_RUN;
            ST_STOP:
                if (stop_w)
                    state_d = ST_WAKE;
            ST_STBY:
                if (stby_w)
                    state_d = ST_WAKE;
            ST_WAKE:
                if (cnt_q == 16'h0000)
                    state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end

    wire leave_halt = (state_q inside {ST_SLEEP, ST_LPSLEEP, ST_STOP, ST_STBY}) && state_d != state_q;
    wire stby_leave = state_q == ST_STBY && state_d == ST_WAKE;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_q <= ST_RUN;
            cnt_q <= 16'h0000;
            stby_exit_q <= 1'b0;
            cpu_wake_q <= 1'b0;
            pin_prev_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            pin_prev_q <= pin_s;
            cpu_wake_q <= (state_q == ST_WAKE && cnt_q == 16'h0000) ||
                          ((state_q == ST_SLEEP || state_q == ST_LPSLEEP) && sleep_w);
            if (state_q == ST_STOP && stop_w)
                cnt_q <= 16'(STOP_WAKE_CYC - SYNC_LAT - 2);
            else if (stby_leave)
                cnt_q <= 16'(STBY_EXIT - SYNC_LAT - 2);
            else if (cnt_q != 16'h0000)
                cnt_q <= cnt_q - 16'h0001;
            if (stby_leave)
                stby_exit_q <= 1'b1;
            else if (state_d == ST_RUN)
                stby_exit_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power, clock and oscillator outputs
    // ------------------------------------------------------------
    always_comb
    begin
        pwr_d = '0;
        pwr_d.cpu_clk_en = state_q inside {ST_RUN, ST_LPRUN};
        pwr_d.core_clk_en = !deep;
        pwr_d.retain = !(state_q == ST_STBY || stby_exit_q);
        pwr_d.flash_ws = ws_of(range, f_eff);
        pwr_d.regulator_off = state_q == ST_STBY;
        pwr_d.regulator_lp = state_q inside {ST_LPRUN, ST_LPSLEEP, ST_STOP};
        // Slow sources follow software across Stop and Standby unless the no-clock variant was chosen; wdg_run_s also holds internal_slow_osc on
        pwr_d.osc.external_slow_osc = ctrl_q[CTRL_EXT_SLOW] & (!deep | rtc_keep);
        pwr_d.osc.internal_slow_osc = ctrl_q[CTRL_INT_SLOW] & (!deep | rtc_keep) | wdg_run_s;
        if (state_q inside {ST_LPRUN, ST_LPSLEEP})
        begin
            pwr_d.osc.multispeed_osc = 1'b1;
            pwr_d.osc.multispeed_low = 1'b1;
        end
        else if (deep)
            pwr_d.osc.internal_fast_osc = state_q == ST_STOP && fast_req_s;
        else
        begin
            pwr_d.osc.pll = ctrl_q[CTRL_PLL];
            pwr_d.osc.internal_fast_osc = ctrl_q[CTRL_INT_FAST];
            pwr_d.osc.external_fast_osc = ctrl_q[CTRL_EXT_FAST];
            pwr_d.osc.multispeed_osc = ctrl_q[CTRL_MULTI];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            pwr_q <= '0;
        else
            pwr_q <= pwr_d;
    end

    assign pwr_out = pwr_q;
    assign cpu_freq_khz_out = f_eff;
    assign cpu_wake_out = cpu_wake_q;
    assign core_reset_out = stby_exit_q;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_q, w_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    wire wr_fire = aw_q && w_q && !bvalid_q;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wval = wdata_q & wmask;
    wire wr_ctrl = wr_fire && awaddr_q == ADDR_CTRL;
    wire wr_freq = wr_fire && awaddr_q == ADDR_FREQ;
    wire wr_stat = wr_fire && awaddr_q == ADDR_STAT;
    wire wr_wake = wr_fire && awaddr_q == ADDR_WAKE;
    wire ar_fire = s_axi_arvalid && !rvalid_q;
    wire [15:0] f_new = (freq_q & ~wmask[15:0]) | wval[15:0];
    wire step_ok = {2'b00, f_new} < {freq_q, 2'b00};
    wire f_take = wr_freq && step_ok && guard_q == 16'h0000;

    wire [31:0] stat_v = {24'h0, guard_q != 16'h0000, lprun_err_q, step_err_q, capped, pwr_q.flash_ws,
                          pwr_q.cpu_clk_en ? (state_q == ST_LPRUN ? MODE_LPRUN : MODE_RUN) : mode_req};
    wire mapped_r = s_axi_araddr inside {ADDR_CTRL, ADDR_FREQ, ADDR_STAT, ADDR_WAKE};
    wire [31:0] rd_v = (s_axi_araddr == ADDR_CTRL) ? {20'h0, ctrl_q} :
                       (s_axi_araddr == ADDR_FREQ) ? {16'h0, freq_q} :
                       (s_axi_araddr == ADDR_STAT) ? stat_v :
                       (s_axi_araddr == ADDR_WAKE) ? {23'h0, wake_q} : 32'h0000_0000;

    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            {aw_q, w_q, bvalid_q, rvalid_q} <= 4'h0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            {bresp_q, rresp_q} <= 4'h0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                {aw_q, w_q} <= 2'b00;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_ctrl | wr_freq | wr_stat | wr_wake) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (ar_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_v;
                rresp_q <= mapped_r ? 2'b00 : 2'b10;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ctrl_q <= CTRL_RST;
            freq_q <= FREQ_RST;
            guard_q <= 16'h0000;
            {step_err_q, lprun_err_q} <= 2'b00;
            wake_q <= 9'h000;
        end
        else
        begin
            // Wake record is standby circuitry and survives the core reset; set wins over clear
            wake_q <= (wake_q & ~(wr_wake ? wval[8:0] : 9'h000)) | (leave_halt ? src : 9'h000);
            if (stby_exit_q)
            begin
                ctrl_q <= CTRL_RST;
                freq_q <= FREQ_RST;
                guard_q <= 16'h0000;
                {step_err_q, lprun_err_q} <= 2'b00;
            end
            else
            begin
                if (wr_ctrl)
                    ctrl_q <= (ctrl_q & ~wmask[11:0]) | wval[11:0];
                else if (leave_halt)
                    ctrl_q[CTRL_MODE_LSB +: 3] <= MODE_RUN;
                if (f_take)
                begin
                    freq_q <= f_new;
                    guard_q <= 16'(FSTEP_CYC - 1);
                end
                else if (guard_q != 16'h0000)
                    guard_q <= guard_q - 16'h0001;
                step_err_q <= (wr_freq && !f_take) |
                              (step_err_q & ~(wr_stat & wval[STAT_STEP_ERR]));
                lprun_err_q <= (state_q == ST_RUN && mode_req == MODE_LPRUN && !lprun_ok) |
                               (lprun_err_q & ~(wr_stat & wval[STAT_LPRUN_ERR]));
            end
        end
    end

endmodule // lpm_ctrl

// ===== src/lpm_pkg.sv
package lpm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL = 8'h00;
    localparam logic [7:0]  ADDR_FREQ = 8'h04;
    localparam logic [7:0]  ADDR_STAT = 8'h08;
    localparam logic [7:0]  ADDR_WAKE = 8'h0C;

    // Control field positions
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_RTC_KEEP = 3;
    localparam int          CTRL_RANGE_LSB = 4;
    localparam int          CTRL_EXT_SLOW = 6;
    localparam int          CTRL_INT_SLOW = 7;
    localparam int          CTRL_PLL = 8;
    localparam int          CTRL_INT_FAST = 9;
    localparam int          CTRL_EXT_FAST = 10;
    localparam int          CTRL_MULTI = 11;
    localparam logic [11:0] CTRL_RST = 12'h820;
    // Status field positions
    localparam int          STAT_WS = 3;
    localparam int          STAT_CAPPED = 4;
    localparam int          STAT_STEP_ERR = 5;
    localparam int          STAT_LPRUN_ERR = 6;
    localparam int          STAT_GUARD = 7;

    // Mode request codes
    localparam logic [2:0]  MODE_RUN = 3'h0;
    localparam logic [2:0]  MODE_SLEEP = 3'h1;
    localparam logic [2:0]  MODE_LPRUN = 3'h2;
    localparam logic [2:0]  MODE_LPSLEEP = 3'h3;
    localparam logic [2:0]  MODE_STOP = 3'h4;
    localparam logic [2:0]  MODE_STBY = 3'h5;

    // ------------------------------------------------------------
    // Frequency limits in kHz
    // ------------------------------------------------------------
    localparam logic [15:0] FREQ_RST = 16'h0800;
    localparam logic [15:0] FMAX_R1 = 16'h7D00;
    localparam logic [15:0] FMAX_R2 = 16'h3E80;
    localparam logic [15:0] FMAX_R3 = 16'h1068;
    localparam logic [15:0] FWS_R1 = 16'h3E80;
    localparam logic [15:0] FWS_R2 = 16'h1F40;
    localparam logic [15:0] FMAX_LPRUN = 16'h0083;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_NS = 4;
    localparam int          T_STOP_WAKE_NS = 3500;
    localparam int          T_FSTEP_NS = 5000;
    localparam int          T_STBY_EXIT_NS = 60000;
    localparam int          SYNC_LAT = 3;
    localparam int          STOP_WAKE_CYC = T_STOP_WAKE_NS / CLK_NS;
    localparam int          FSTEP_CYC = (T_FSTEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          STBY_EXIT_CYC = T_STBY_EXIT_NS / CLK_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] gpio;
        logic        voltage_detector;
        logic        comp1;
        logic        comp2;
        logic [4:0]  rtc;
        logic [2:0]  serial;
        logic        low_power_timer;
    } lpm_wake_src_t;

    typedef struct packed {
        logic pll;
        logic multispeed_osc;
        logic multispeed_low;
        logic internal_fast_osc;
        logic external_fast_osc;
        logic external_slow_osc;
        logic internal_slow_osc;
    } lpm_osc_en_t;

    typedef struct packed {
        logic        cpu_clk_en;
        logic        core_clk_en;
        logic        regulator_lp;
        logic        regulator_off;
        logic        retain;
        logic        flash_ws;
        lpm_osc_en_t osc;
    } lpm_pwr_t;

endpackage

// ===== testbench/lpm_core_model.sv
`timescale 1ns/100ps
module lpm_core_model #(
    parameter int DELAY = 3
)(
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic go_in,
    input  wire logic cpu_wake_in,
    output logic      halt_ready_out
);
    // ----------------------------------------
    // Halt handshake
    // ----------------------------------------
    // Core needs a few cycles to finish its pipeline before it may halt
    logic       armed_q;
    logic [3:0] cnt_q;
    assign halt_ready_out = armed_q && (cnt_q == 4'(DELAY));
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || !go_in || cpu_wake_in)
        begin
            armed_q <= !cpu_wake_in;
            cnt_q   <= 4'h0;
        end
        else if (cnt_q != 4'(DELAY))
            cnt_q <= cnt_q + 4'h1;
    end
endmodule // lpm_core_model

// ===== testbench/lpm_ctrl_checker.sv
`timescale 1ns/100ps
module lpm_ctrl_checker
    import lpm_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          rstn_in,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    input wire logic [31:0]   s_axi_rdata,
    input wire lpm_wake_src_t wake_src_in,
    input wire logic          periph_irq_in,
    input wire lpm_pwr_t      pwr_out,
    input wire logic [15:0]   cpu_freq_khz_out,
    input wire logic          cpu_wake_out
);
    // ----------------------------------------
    // Mode decoding
    // ----------------------------------------
    // Power word is all zero for an edge after reset, so modes are ignored then
    logic [1:0] up_q;
    always_ff @(posedge clk_in)
        up_q <= {up_q[0], rstn_in};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence in_stop;
        up_q[1] && !pwr_out.core_clk_en && !pwr_out.regulator_off;
    endsequence
    sequence in_sleep;
        up_q[1] && !pwr_out.cpu_clk_en && pwr_out.core_clk_en;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    freq_cap_a: assert property (cpu_freq_khz_out <= FMAX_R1)
        else $error("cpu frequency above top cap");
    stop_osc_a: assert property (in_stop |-> !pwr_out.osc.pll && !pwr_out.osc.multispeed_osc
        && !pwr_out.osc.external_fast_osc && (!$fell(pwr_out.core_clk_en) || pwr_out.regulator_lp && pwr_out.retain))
        else $error("stop power word wrong");
    stby_off_a: assert property (pwr_out.regulator_off |-> !pwr_out.retain && !pwr_out.cpu_clk_en
        && !pwr_out.osc.pll && !pwr_out.osc.multispeed_osc) else $error("standby power word wrong");
    sleep_wake_a: assert property (in_sleep ##0 $rose(periph_irq_in) |-> ##[1:12] cpu_wake_out)
        else $error("sleep not left on interrupt");
    stop_wake_a: assert property (in_stop ##0 $rose(|wake_src_in.gpio) |-> ##[1:874] cpu_wake_out)
        else $error("stop not left in time");
    wake_run_a: assert property (cpu_wake_out |-> ##[0:4] (pwr_out.cpu_clk_en && !pwr_out.regulator_lp))
        else $error("wake did not return to run");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // lpm_ctrl_checker

bind lpm_ctrl lpm_ctrl_checker u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .wake_src_in(wake_src_in), .periph_irq_in(periph_irq_in),
    .pwr_out(pwr_out), .cpu_freq_khz_out(cpu_freq_khz_out), .cpu_wake_out(cpu_wake_out));

// ===== testbench/lpm_ctrl_tb_top.sv
`timescale 1ns/100ps
module lpm_ctrl_tb_top
    import lpm_pkg::*;
;
    logic          clk_in, rstn_in, go;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata, q;
    logic [3:0]    s_axi_wstrb;
    logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp, r;
    logic          cpu_halt_ready_in, periph_irq_in, vref_on_in, external_reset_pin_n_in;
    logic          independent_watchdog_rst_in, independent_watchdog_run_in, fast_osc_req_in;
    logic [2:0]    wake_pin_in;
    lpm_wake_src_t wake_src_in;
    lpm_pwr_t      pwr_out;
    logic [15:0]   cpu_freq_khz_out;
    logic          cpu_wake_out, core_reset_out;
    int            bad_count, num_checks, cyc;

    lpm_ctrl #(.STBY_EXIT(20)) u_dut (.*);
    lpm_core_model u_core (.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .cpu_wake_in(cpu_wake_out),
        .halt_ready_out(cpu_halt_ready_in));

    // ----------------------------------------
    // Clock, timeout and bus tasks
    // ----------------------------------------
    initial
    begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        if (wr)
        begin
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end
        else
        begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        forever
        begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (wr && s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
            if (!wr && s_axi_rvalid)
            begin
                {q, r} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axi(1'h0, a, 32'h0000_0000);
        chk(q & m, e);
    endtask
    task automatic enter(input logic [31:0] c);
        axi(1'h1, ADDR_CTRL, c);
        go <= 1'h1;
        tick(12);
    endtask
    task automatic wake();
        int n = 0;
        while (cpu_wake_out !== 1'h1 && n < 1000)
        begin
            @(posedge clk_in);
            n++;
        end
        chk(cpu_wake_out, 32'h0000_0001);
        go <= 1'h0;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        {rstn_in, go, periph_irq_in, vref_on_in, fast_osc_req_in, wake_pin_in} = 8'h00;
        {independent_watchdog_rst_in, independent_watchdog_run_in, external_reset_pin_n_in} = 3'h3;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000F;
        wake_src_in = '0;
        tick(4);
        rstn_in <= 1'h1;
        rdc(ADDR_CTRL, 32'h0000_FFFF, {20'h0_0000, CTRL_RST});
        rdc(ADDR_FREQ, 32'h0000_FFFF, {16'h0000, FREQ_RST});
        axi(1'h0, 8'h10, 32'h0000_0000);
        chk(r, 32'h0000_0002);
        axi(1'h1, ADDR_FREQ, 32'h0000_2000);
        rdc(ADDR_FREQ, 32'h0000_FFFF, {16'h0000, FREQ_RST});
        rdc(ADDR_STAT, 32'h0000_0020, 32'h0000_0020);
        tick(1300);
        axi(1'h1, ADDR_FREQ, 32'h0000_1F40);
        axi(1'h1, ADDR_FREQ, 32'h0000_07D0);
        rdc(ADDR_FREQ, 32'h0000_FFFF, 32'h0000_1F40);
        chk(pwr_out.flash_ws, 32'h0000_0000);
        tick(1300);
        axi(1'h1, ADDR_FREQ, {16'h0000, FMAX_R2});
        tick(2);
        chk(pwr_out.flash_ws, 32'h0000_0001);
        axi(1'h1, ADDR_CTRL, 32'h0000_0830);
        tick(2);
        chk({pwr_out.flash_ws, cpu_freq_khz_out}, {1'h0, FMAX_R3});
        axi(1'h1, ADDR_CTRL, 32'h0000_0810);
        tick(2);
        chk({pwr_out.flash_ws, cpu_freq_khz_out}, {1'h0, FMAX_R2});
        tick(1300);
        axi(1'h1, ADDR_FREQ, 32'h0000_4E20);
        tick(2);
        chk(pwr_out.flash_ws, 32'h0000_0001);
        axi(1'h1, ADDR_CTRL, 32'h0000_0812);
        rdc(ADDR_STAT, 32'h0000_0047, 32'h0000_0040);
        tick(1300);
        axi(1'h1, ADDR_FREQ, {16'h0000, FMAX_LPRUN});
        axi(1'h1, ADDR_CTRL, 32'h0000_0812);
        tick(3);
        chk({pwr_out.regulator_lp, pwr_out.osc.multispeed_low}, 32'h0000_0003);
        axi(1'h1, ADDR_CTRL, 32'h0000_0821);
        tick(10);
        chk(pwr_out.cpu_clk_en, 32'h0000_0001);
        go <= 1'h1;
        tick(12);
        chk({pwr_out.cpu_clk_en, pwr_out.core_clk_en}, 32'h0000_0001);
        periph_irq_in <= 1'h1;
        wake();
        periph_irq_in <= 1'h0;
        enter(32'h0000_0823);
        chk({pwr_out.cpu_clk_en, pwr_out.regulator_lp}, 32'h0000_0001);
        periph_irq_in <= 1'h1;
        wake();
        periph_irq_in <= 1'h0;
        tick(4);
        chk(pwr_out.regulator_lp, 32'h0000_0000);
        enter(32'h0000_086C);
        chk({pwr_out.core_clk_en, pwr_out.regulator_lp, pwr_out.osc.pll}, 32'h0000_0002);
        chk(pwr_out.osc.external_slow_osc, 32'h0000_0001);
        fast_osc_req_in <= 1'h1;
        tick(5);
        chk(pwr_out.osc.internal_fast_osc, 32'h0000_0001);
        fast_osc_req_in <= 1'h0;
        wake_src_in.gpio[3] <= 1'h1;
        wake();
        rdc(ADDR_WAKE, 32'h0000_0002, 32'h0000_0002);
        axi(1'h1, ADDR_WAKE, 32'h0000_01FF);
        wake_src_in <= '0;
        enter(32'h0000_0864);
        chk(pwr_out.osc.internal_slow_osc, 32'h0000_0001);
        independent_watchdog_run_in <= 1'h0;
        wake_src_in.rtc[0] <= 1'h1;
        tick(900);
        chk({pwr_out.osc.external_slow_osc, pwr_out.osc.internal_slow_osc}, 32'h0000_0000);
        rdc(ADDR_STAT, 32'h0000_0007, {29'h0, MODE_STOP});
        wake_src_in.comp1 <= 1'h1;
        wake();
        rdc(ADDR_WAKE, 32'h0000_0018, 32'h0000_0008);
        axi(1'h1, ADDR_WAKE, 32'h0000_01FF);
        enter(32'h0000_0865);
        go <= 1'h0;
        chk({pwr_out.regulator_off, pwr_out.retain}, 32'h0000_0002);
        wake_src_in.rtc[1] <= 1'h1;
        tick(100);
        chk(pwr_out.regulator_off, 32'h0000_0001);
        wake_pin_in[1] <= 1'h1;
        tick(8);
        chk({core_reset_out, pwr_out.retain}, 32'h0000_0002);
        tick(92);
        rdc(ADDR_STAT, 32'h0000_0007, {29'h0, MODE_RUN});
        rdc(ADDR_WAKE, 32'h0000_0050, 32'h0000_0040);
        end_sim();
    end
endmodule // lpm_ctrl_tb_top
